/* verilog/dbg_ext_pkg.sv */
// constants and types for the debug direction qualifier and trace extension
// assumes a 32-bit avalon-mm slave with one register per aligned word
package dbg_ext_pkg;
	localparam int AVS_ADDR_W = 6;
	localparam int AVS_DATA_W = 32;
	localparam int REG_W = 8;
	localparam logic [15:0] DEBUG_BASE = 16'h3010;
	// register indices; byte address is four times the index
	localparam logic [3:0] IDX_FH = 4'h6;
	localparam logic [3:0] IDX_FL = 4'h7;
	localparam logic [3:0] IDX_CAX = 4'h8;
	localparam logic [3:0] IDX_CBX = 4'h9;
	localparam logic [3:0] IDX_CCX = 4'hA;
	localparam logic [3:0] IDX_FX = 4'hB;
	localparam logic [3:0] IDX_CTRL = 4'hC;
	localparam logic [3:0] IDX_TRIG = 4'hD;
	localparam int DIR_EN_BIT = 7;
	localparam int DIR_VAL_BIT = 6;
	localparam int FX_PAGED_BIT = 7;
	localparam int FX_MSB_BIT = 0;
	localparam int CTRL_EN_BIT = 7;
	localparam int CTRL_ARM_BIT = 6;
	localparam int CTRL_TAG_BIT = 5;
	localparam int CTRL_BRK_BIT = 4;
	localparam int CTRL_LOOP_BIT = 0;
	localparam int TRIG_BEGIN_BIT = 6;
	localparam int TRIG_FULL_BIT = 0;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] CTRL_WMASK = 8'hF1;
	localparam logic [7:0] TRIG_WMASK = 8'h41;
	localparam int CPU_ADDR_W = 16;
	localparam int PAGE_W = 3;
	localparam int PAGE_OFS_W = 14;
	localparam int TRACE_DEPTH = 8;
	localparam int NUM_CMP = 3;
	localparam int CMP_A = 0;
	localparam int CMP_B = 1;
	localparam int CMP_C = 2;
	typedef struct packed {
		logic en;
		logic val;
	} dir_cfg_t;
	typedef struct packed {
		logic paged;
		logic msb;
		logic [15:0] data;
	} trace_entry_t;
	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_ANSWER = 1'b1
	} bus_state_t;
endpackage

/* verilog/dir_qualifier.sv */
// one comparator's read/write qualification of an address hit
// assumes the address compare result arrives in the bus cycle it belongs to
`timescale 1ns/1ps
module dir_qualifier
	import dbg_ext_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic bus_valid,
	input wire logic bus_read,
	input wire logic addr_hit,
	input wire dir_cfg_t cfg,
	output logic match
);
	logic next_match;
	always_comb begin
		next_match = 1'b0;
		if (bus_valid && addr_hit) begin
			// direction counts only while enabled; 1 reads, 0 writes
			next_match = !cfg.en || (bus_read == cfg.val);
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			match <= 1'b0;
		end else begin
			match <= next_match;
		end
	end
endmodule

/* verilog/trace_mem.sv */
// small trace word store with registered read data
// assumes one writer and one reader, both on sys_clk
`timescale 1ns/1ps
module trace_mem #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 8,
	parameter int PTR_W = $clog2(DEPTH)
) (
	input wire logic sys_clk,
	input wire logic wr_en,
	input wire logic [PTR_W-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [PTR_W-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem [DEPTH];
	always_ff @(posedge sys_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule

/* verilog/dbg_compare_trace.sv */
// debug comparator direction qualifiers and trace word extension
// assumes address hits and capture requests are synchronous to sys_clk
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps
module dbg_compare_trace
	import dbg_ext_pkg::*;
#(
	parameter int DEPTH = TRACE_DEPTH
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic end_run_reset,
	input wire logic secure,
	input wire logic [AVS_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [AVS_DATA_W-1:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [AVS_DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic bus_valid,
	input wire logic bus_read,
	input wire logic [NUM_CMP-1:0] addr_hit,
	output logic [NUM_CMP-1:0] match,
	input wire logic capture_valid,
	input wire logic capture_event,
	input wire logic [CPU_ADDR_W-1:0] cpu_addr,
	input wire logic [PAGE_W-1:0] page,
	input wire logic page_sel,
	input wire logic [15:0] event_data,
	output logic debug_module_enable,
	output logic capture_armed
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
	localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
	localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);

	bus_state_t state, next_state;
	logic [REG_W-1:0] cax, cbx, ccx, ctrl, trig;
	logic [REG_W-1:0] next_cax, next_cbx, next_ccx, next_ctrl, next_trig;
	logic [PTR_W-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [CNT_W-1:0] count, next_count;
	logic [AVS_DATA_W-1:0] next_readdata;
	logic [3:0] idx;
	logic req, wr_taken, rd_taken, hold, push, pop, full_mode;
	logic [REG_W-1:0] wbyte, fx_byte, fh_byte, fl_byte;
	logic [CPU_ADDR_W:0] cap_addr;
	trace_entry_t cap_entry, cur_entry;
	dir_cfg_t cfg [NUM_CMP];

	assign idx = avs_address[AVS_ADDR_W-1:2];
	assign req = avs_read || avs_write;
	assign avs_waitrequest = req && (state == BUS_IDLE);
	assign wr_taken = avs_write && (state == BUS_ANSWER);
	assign rd_taken = avs_read && (state == BUS_ANSWER);
	assign wbyte = avs_byteenable[0] ? avs_writedata[REG_W-1:0] : REG_RESET;
	assign debug_module_enable = ctrl[CTRL_EN_BIT];
	assign capture_armed = ctrl[CTRL_ARM_BIT];
	assign full_mode = trig[TRIG_FULL_BIT];
	// end-trace reset with enable set and end trigger keeps the registers and trace fifo, except that the arm and break bits of ctrl clear
	assign hold = end_run_reset && ctrl[CTRL_EN_BIT]
		&& !trig[TRIG_BEGIN_BIT];

	// bus handshake: one wait cycle, then the answer
	always_comb begin
		next_state = state;
		unique case (state)
			BUS_IDLE: begin
				if (req) begin
					next_state = BUS_ANSWER;
				end
			end
			BUS_ANSWER: begin
				next_state = BUS_IDLE;
			end
		endcase
	end
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state <= BUS_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// trace word assembly
	always_comb begin
		if (page_sel) begin
			cap_addr = {page, cpu_addr[PAGE_OFS_W-1:0]};
		end else begin
			cap_addr = {1'b0, cpu_addr};
		end
		cap_entry.paged = page_sel && !capture_event;
		cap_entry.msb = capture_event ? 1'b0 : cap_addr[CPU_ADDR_W];
		cap_entry.data = capture_event ? event_data
			: cap_addr[CPU_ADDR_W-1:0];
	end
	assign push = capture_valid && ctrl[CTRL_EN_BIT] && ctrl[CTRL_ARM_BIT]
		&& (count != CNT_FULL);
	// low byte read moves to the next word
	assign pop = rd_taken && (idx == IDX_FL) && (count != '0);

	trace_mem #(
		.WIDTH($bits(trace_entry_t)),
		.DEPTH(DEPTH),
		.PTR_W(PTR_W)
	) u_mem (
		.sys_clk(sys_clk),
		.wr_en(push),
		.wr_addr(wr_ptr),
		.wr_data(cap_entry),
		.rd_addr(rd_ptr),
		.rd_data(cur_entry)
	);

	// visible word: all three bytes from one entry, zero when empty
	always_comb begin
		fx_byte = REG_RESET;
		fh_byte = REG_RESET;
		fl_byte = REG_RESET;
		if (count != '0) begin
			fx_byte[FX_PAGED_BIT] = cur_entry.paged;
			fx_byte[FX_MSB_BIT] = cur_entry.msb;
			fh_byte = cur_entry.data[15:8];
			fl_byte = cur_entry.data[7:0];
		end
	end

	// fifo pointers
	always_comb begin
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_count = count;
		if (!rst_n) begin
			if (!hold) begin
				next_wr_ptr = '0;
				next_rd_ptr = '0;
				next_count = '0;
			end
		end else begin
			if (push) begin
				next_wr_ptr = wr_ptr + PTR_ONE;
			end
			if (pop) begin
				next_rd_ptr = rd_ptr + PTR_ONE;
			end
			if (push && !pop) begin
				next_count = count + CNT_ONE;
			end else if (pop && !push) begin
				next_count = count - CNT_ONE;
			end
		end
	end
	always_ff @(posedge sys_clk) begin
		wr_ptr <= next_wr_ptr;
		rd_ptr <= next_rd_ptr;
		count <= next_count;
	end

	// software registers
	always_comb begin
		next_cax = cax;
		next_cbx = cbx;
		next_ccx = ccx;
		next_ctrl = ctrl;
		next_trig = trig;
		if (!rst_n) begin
			if (hold) begin
				next_ctrl[CTRL_ARM_BIT] = 1'b0;
				next_ctrl[CTRL_BRK_BIT] = 1'b0;
			end else begin
				next_cax = REG_RESET;
				next_cbx = REG_RESET;
				next_ccx = REG_RESET;
				next_ctrl = REG_RESET;
				next_trig = REG_RESET;
			end
		end else if (wr_taken) begin
			unique case (idx)
				IDX_CAX: next_cax = {wbyte[7:6], 6'h00};
				IDX_CBX: next_cbx = {wbyte[7:6], 6'h00};
				IDX_CCX: next_ccx = {wbyte[7:6], 6'h00};
				IDX_CTRL: next_ctrl = wbyte & CTRL_WMASK;
				IDX_TRIG: begin
					if (!ctrl[CTRL_ARM_BIT]) begin
						next_trig = wbyte & TRIG_WMASK;
					end
				end
				default: begin
				end
			endcase
		end
		if (secure) begin
			next_ctrl[CTRL_EN_BIT] = 1'b0;
		end
	end
	always_ff @(posedge sys_clk) begin
		cax <= next_cax;
		cbx <= next_cbx;
		ccx <= next_ccx;
		ctrl <= next_ctrl;
		trig <= next_trig;
	end

	// read data latched in the wait cycle
	always_comb begin
		next_readdata = avs_readdata;
		if (!rst_n) begin
			next_readdata = '0;
		end else if (req && (state == BUS_IDLE)) begin
			next_readdata = '0;
			if (avs_read) begin
				unique case (idx)
					IDX_FH: next_readdata[REG_W-1:0] = fh_byte;
					IDX_FL: next_readdata[REG_W-1:0] = fl_byte;
					IDX_CAX: next_readdata[REG_W-1:0] = cax;
					IDX_CBX: next_readdata[REG_W-1:0] = cbx;
					IDX_CCX: next_readdata[REG_W-1:0] = ccx;
					IDX_FX: next_readdata[REG_W-1:0] = fx_byte;
					IDX_CTRL: next_readdata[REG_W-1:0] = ctrl;
					IDX_TRIG: next_readdata[REG_W-1:0] = trig;
					default: next_readdata = '0;
				endcase
			end
		end
	end
	always_ff @(posedge sys_clk) begin
		avs_readdata <= next_readdata;
	end

	// direction settings per comparator; b borrows a in full mode
	always_comb begin
		cfg[CMP_A] = '{en: cax[DIR_EN_BIT], val: cax[DIR_VAL_BIT]};
		cfg[CMP_B] = '{en: cbx[DIR_EN_BIT], val: cbx[DIR_VAL_BIT]};
		cfg[CMP_C] = '{en: ccx[DIR_EN_BIT], val: ccx[DIR_VAL_BIT]};
		if (full_mode) begin
			cfg[CMP_B] = cfg[CMP_A];
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_CMP; g++) begin : g_cmp
			dir_qualifier u_q (
				.sys_clk(sys_clk),
				.rst_n(rst_n),
				.bus_valid(bus_valid),
				.bus_read(bus_read),
				.addr_hit(addr_hit[g]),
				.cfg(cfg[g]),
				.match(match[g])
			);
		end
	endgenerate

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence s_req_wait;
		req && (state == BUS_IDLE);
	endsequence
	sequence s_answer;
		!avs_waitrequest ##1 !avs_waitrequest || !req;
	endsequence
	property p_bus_answer;
		s_req_wait |=> !avs_waitrequest;
	endproperty
	a_bus_answer: assert property (p_bus_answer)
		else $error("request not answered after one wait cycle");

	property p_reset_clear;
		$rose(rst_n) && !$past(hold) |->
			cbx == REG_RESET && ccx == REG_RESET && count == '0;
	endproperty
	a_reset_clear: assert property (p_reset_clear)
		else $error("registers not cleared by ordinary reset");

	property p_reset_hold;
		$rose(rst_n) && $past(hold) |->
			cbx == $past(cbx, 2) && ccx == $past(ccx, 2);
	endproperty
	a_reset_hold: assert property (p_reset_hold)
		else $error("held reset changed qualifier registers");

	property p_b_dir;
		bus_valid && addr_hit[CMP_B] && !full_mode && cbx[DIR_EN_BIT]
			&& (bus_read != cbx[DIR_VAL_BIT]) |=> !match[CMP_B];
	endproperty
	a_b_dir: assert property (p_b_dir)
		else $error("comparator b matched the wrong direction");

	property p_b_full;
		bus_valid && addr_hit[CMP_B] && full_mode && cax[DIR_EN_BIT]
			&& (bus_read != cax[DIR_VAL_BIT]) |=> !match[CMP_B];
	endproperty
	a_b_full: assert property (p_b_full)
		else $error("full mode did not use comparator a direction");

	property p_c_open;
		bus_valid && addr_hit[CMP_C] && !ccx[DIR_EN_BIT] |=> match[CMP_C];
	endproperty
	a_c_open: assert property (p_c_open)
		else $error("comparator c missed a hit with direction off");

	property p_c_dir;
		bus_valid && addr_hit[CMP_C] && ccx[DIR_EN_BIT]
			&& (bus_read == ccx[DIR_VAL_BIT]) |=> match[CMP_C];
	endproperty
	a_c_dir: assert property (p_c_dir)
		else $error("comparator c missed a matching direction");

	property p_match_cause;
		match[CMP_B] |-> $past(bus_valid && addr_hit[CMP_B]);
	endproperty
	a_match_cause: assert property (p_match_cause)
		else $error("match without an address hit");

	property p_reserved;
		(s_req_wait and (avs_read && (idx == IDX_CBX || idx == IDX_FX)))
			|=> avs_readdata[5:1] == 5'h00 && avs_readdata[31:8] == '0;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved bits read nonzero");

	property p_secure;
		secure |=> !debug_module_enable;
	endproperty
	a_secure: assert property (p_secure)
		else $error("enable set while secure");

	property p_pop;
		pop && !push |=> count == $past(count) - CNT_ONE
			&& rd_ptr == $past(rd_ptr) + PTR_ONE;
	endproperty
	a_pop: assert property (p_pop)
		else $error("low byte read did not advance the fifo");
endmodule

/* verification/cpu_bus_model.sv */
// core bus cycles and trace capture requests for the debug slice
// assumes the bench calls its tasks and keeps them one at a time
`timescale 1ns/1ps
module cpu_bus_model
	import dbg_ext_pkg::*;
(
	input wire logic sys_clk,
	output logic bus_valid,
	output logic bus_read,
	output logic [NUM_CMP-1:0] addr_hit,
	output logic capture_valid,
	output logic capture_event,
	output logic [CPU_ADDR_W-1:0] cpu_addr,
	output logic [PAGE_W-1:0] page,
	output logic page_sel,
	output logic [15:0] event_data
);
	initial begin
		bus_valid = 1'b0;
		bus_read = 1'b0;
		addr_hit = 3'h0;
		capture_valid = 1'b0;
		capture_event = 1'b0;
		cpu_addr = 16'h0;
		page = 3'h0;
		page_sel = 1'b0;
		event_data = 16'h0;
	end
	// one qualified bus cycle; idle lines show the inverse afterwards
	task automatic cycle(input logic rd, input logic [2:0] hit);
		@(posedge sys_clk);
		bus_valid <= 1'b1;
		bus_read <= rd;
		addr_hit <= hit;
		@(posedge sys_clk);
		bus_valid <= 1'b0;
		bus_read <= ~rd;
		addr_hit <= ~hit;
	endtask
	task automatic capture(input logic ev, input logic ps,
		input logic [2:0] pg, input logic [15:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		capture_valid <= 1'b1;
		capture_event <= ev;
		page_sel <= ps;
		page <= pg;
		cpu_addr <= a;
		event_data <= d;
		@(posedge sys_clk);
		capture_valid <= 1'b0;
		capture_event <= ~ev;
		page_sel <= ~ps;
		page <= ~pg;
		cpu_addr <= ~a;
		event_data <= ~d;
	endtask
endmodule

/* verification/debug_compare_rw_and_trace_extension_tb_top.sv */
// self-checking bench for the direction qualifiers and trace extension
// assumes the core bus model drives the far side of the slice
`timescale 1ns/1ps
module debug_compare_rw_and_trace_extension_tb_top
	import dbg_ext_pkg::*;
;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic end_run_reset = 1'b0;
	logic secure = 1'b0;
	logic [5:0] avs_address = 6'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic bus_valid, bus_read, capture_valid, capture_event, page_sel;
	logic [2:0] addr_hit, match, page;
	logic [15:0] cpu_addr, event_data;
	logic debug_module_enable, capture_armed;
	int failures = 0;
	int checks_done = 0;
	cpu_bus_model bus (.sys_clk(sys_clk), .bus_valid(bus_valid),
		.bus_read(bus_read), .addr_hit(addr_hit),
		.capture_valid(capture_valid), .capture_event(capture_event),
		.cpu_addr(cpu_addr), .page(page), .page_sel(page_sel),
		.event_data(event_data));
	dbg_compare_trace dut (.sys_clk(sys_clk), .rst_n(rst_n),
		.end_run_reset(end_run_reset), .secure(secure),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .bus_valid(bus_valid),
		.bus_read(bus_read), .addr_hit(addr_hit), .match(match),
		.capture_valid(capture_valid), .capture_event(capture_event),
		.cpu_addr(cpu_addr), .page(page), .page_sel(page_sel),
		.event_data(event_data), .debug_module_enable(debug_module_enable),
		.capture_armed(capture_armed));
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// request held until waitrequest is seen low at a rising edge
	task automatic av(input logic wr, input logic [3:0] idx,
		input logic [7:0] wd, output logic [7:0] rd);
		int n;
		n = 0;
		@(posedge sys_clk);
		avs_address <= {idx, 2'b00};
		avs_write <= wr;
		avs_read <= ~wr;
		avs_writedata <= {24'h0, wd};
		@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0 && n < 50) begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= 50)
			failures++;
		rd = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic wr(input logic [3:0] idx, input logic [7:0] d);
		logic [7:0] x;
		av(1'b1, idx, d, x);
	endtask
	task automatic rc(input logic [3:0] idx, input logic [7:0] exp);
		logic [7:0] x;
		av(1'b0, idx, 8'h0, x);
		chk({8'h0, x}, {8'h0, exp});
	endtask
	task automatic do_reset(input logic er);
		@(posedge sys_clk);
		rst_n <= 1'b0;
		end_run_reset <= er;
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		end_run_reset <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic t_reset_values();
		logic [3:0] idx [6] = '{IDX_CAX, IDX_CBX, IDX_CCX, IDX_FX, IDX_CTRL,
			IDX_TRIG};
		foreach (idx[i])
			rc(idx[i], REG_RESET);
	endtask
	task automatic t_reserved();
		wr(IDX_CBX, 8'hFF);
		rc(IDX_CBX, 8'hC0);
		wr(IDX_CCX, 8'hFF);
		rc(IDX_CCX, 8'hC0);
		wr(IDX_FX, 8'hFF);
		rc(IDX_FX, 8'h00);
		wr(IDX_CTRL, 8'h31);
		rc(IDX_CTRL, 8'h31);
		wr(4'hF, 8'hFF);
		rc(4'hF, 8'h00);
		wr(IDX_CTRL, 8'h00);
	endtask
	task automatic t_direction();
		logic [2:0] e;
		for (int c = 1; c <= 2; c++) begin
			for (int cfg = 0; cfg < 4; cfg++) begin
				wr(c == 1 ? IDX_CBX : IDX_CCX, {cfg[1:0], 6'h0});
				for (int k = 0; k < 4; k++) begin
					bus.cycle(k[0], k[1] ? 3'(1 << c) : 3'h0);
					e = (k[1] && (!cfg[1] || cfg[0] == k[0])) ? 3'(1 << c) : 3'h0;
					@(negedge sys_clk);
					chk({13'h0, match}, {13'h0, e});
				end
			end
		end
	endtask
	task automatic t_full_mode();
		wr(IDX_TRIG, 8'h01);
		wr(IDX_CAX, 8'hC0);
		wr(IDX_CBX, 8'h80);
		bus.cycle(1'b1, 3'h2);
		@(negedge sys_clk);
		chk({13'h0, match}, 16'h2);
		bus.cycle(1'b0, 3'h2);
		@(negedge sys_clk);
		chk({13'h0, match}, 16'h0);
		wr(IDX_TRIG, 8'h00);
		wr(IDX_CAX, 8'h00);
	endtask
	task automatic t_trace();
		logic [7:0] fx [4] = '{8'h81, 8'h00, 8'h00, 8'h80};
		logic [15:0] dt [4] = '{16'h7FFF, 16'hA5C3, 16'h1234, 16'h8001};
		wr(IDX_CTRL, 8'hC0);
		@(negedge sys_clk);
		chk({14'h0, debug_module_enable, capture_armed}, 16'h3);
		bus.capture(1'b0, 1'b1, 3'h5, 16'hFFFF, 16'h0);
		bus.capture(1'b0, 1'b0, 3'h2, 16'hA5C3, 16'h0);
		bus.capture(1'b1, 1'b0, 3'h0, 16'h0000, 16'h1234);
		bus.capture(1'b0, 1'b1, 3'h2, 16'h8001, 16'h0);
		repeat (2) @(posedge sys_clk);
		foreach (fx[i]) begin
			rc(IDX_FX, fx[i]);
			rc(IDX_FH, dt[i][15:8]);
			rc(IDX_FL, dt[i][7:0]);
		end
		rc(IDX_FX, 8'h00);
		rc(IDX_FL, 8'h00);
		wr(IDX_CTRL, 8'h00);
	endtask
	task automatic t_secure();
		secure <= 1'b1;
		wr(IDX_CTRL, 8'h80);
		rc(IDX_CTRL, 8'h00);
		chk({15'h0, debug_module_enable}, 16'h0);
		secure <= 1'b0;
	endtask
	task automatic t_hold();
		wr(IDX_CTRL, 8'h80);
		wr(IDX_TRIG, 8'h00);
		wr(IDX_CBX, 8'hC0);
		wr(IDX_CCX, 8'h40);
		do_reset(1'b1);
		rc(IDX_CBX, 8'hC0);
		rc(IDX_CCX, 8'h40);
		chk({15'h0, debug_module_enable}, 16'h1);
		do_reset(1'b0);
		rc(IDX_CBX, 8'h00);
		rc(IDX_CCX, 8'h00);
	endtask
	task automatic report_and_stop();
		if (failures == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge sys_clk);
		failures++;
		report_and_stop();
	end
	initial begin
		do_reset(1'b0);
		t_reset_values();
		t_reserved();
		t_direction();
		t_full_mode();
		t_trace();
		t_secure();
		t_hold();
		report_and_stop();
	end
endmodule
